// >>> hdl/acr_pkg.sv
// Purpose: shared constants and carriers of the converter control block
// Assumes: 32-bit APB, byte registers in the low bits of aligned words
// Notes: one clock; converter clock is an enable pulse from a prescaler
package acr_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] OFS_INPUT_GAIN_SELECT = 8'h00;
    localparam logic [7:0] OFS_CONTROL_STATUS = 8'h04;
    localparam logic [7:0] OFS_CONTROL_B = 8'h08;
    localparam logic [7:0] OFS_RESULT_LOW = 8'h0C;
    localparam logic [7:0] OFS_RESULT_HIGH = 8'h10;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [31:0] RST_WORD = 32'h00000000;

    // control/status bit positions, then left adjust of input select
    localparam int BIT_ENABLE = 7;
    localparam int BIT_START = 6;
    localparam int BIT_AUTO = 5;
    localparam int BIT_FLAG = 4;
    localparam int BIT_IRQ_EN = 3;
    localparam int BIT_LEFT_ADJ = 5;

    // ************************************************************
    // input select codes and timing
    // ************************************************************
    localparam logic [4:0] SEL_LAST_SINGLE = 5'h07;
    localparam logic [4:0] SEL_FIRST_X1 = 5'h10;
    localparam logic [4:0] SEL_BANDGAP = 5'h1E;
    localparam logic [4:0] SEL_GROUND = 5'h1F;
    localparam logic [2:0] TS_FREE_RUN = 3'h0;
    localparam logic [4:0] CONV_LAST_FIRST = 5'h18; // 25 cycles
    localparam logic [4:0] CONV_LAST_NORMAL = 5'h0C; // 13 cycles
    localparam logic [4:0] CONV_ZERO = 5'h00;
    localparam logic [6:0] PRE_ZERO = 7'h00;

    function automatic logic [6:0] div_last(input logic [2:0] code);
        case (code)
            3'h2: div_last = 7'h03;
            3'h3: div_last = 7'h07;
            3'h4: div_last = 7'h0F;
            3'h5: div_last = 7'h1F;
            3'h6: div_last = 7'h3F;
            3'h7: div_last = 7'h7F;
            default: div_last = 7'h01;
        endcase
    endfunction : div_last

    typedef enum logic [1:0] {
        ACR_GAIN_1X = 2'b00,
        ACR_GAIN_10X = 2'b01,
        ACR_GAIN_200X = 2'b10
    } acr_gain_e;

    typedef enum logic [0:0] {
        ACR_IDLE = 1'b0,
        ACR_CONVERT = 1'b1
    } acr_fsm_e;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic [4:0] channel;
        acr_gain_e gain;
        logic differential;
        logic start;
    } acr_core_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } acr_apb_rsp_s;

    typedef struct packed {
        acr_fsm_e fsm;
        logic [1:0] ref_sel;
        logic left_adjust;
        logic [4:0] input_select_field;
        logic converter_enable;
        logic auto_trigger_enable;
        logic completion_flag;
        logic completion_irq_enable;
        logic [2:0] clock_divider_select;
        logic [2:0] trigger_source_select;
        logic first_pending;
        logic [6:0] pre_cnt;
        logic [4:0] conv_cnt;
        logic conv_diff;
        logic [9:0] result;
        logic read_lock;
        logic [6:0] trig_meta;
        logic [6:0] trig_sync;
        logic trig_prev;
        logic irq;
        acr_core_req_s core;
        acr_apb_rsp_s apb;
    } acr_state_s;
endpackage : acr_pkg

// >>> hdl/acr_adc_control.sv
// Purpose: control, status and result registers of a 10-bit converter
// Assumes: analog core answers with a code sampled at conversion end
// Notes: APB slave with one wait state; all state in one struct
//
// Overview of operation
// - input select applies after running conversion ends
// - codes 0-7 single inputs, bandgap, ground
// - higher codes differential pairs with gain
// - enable bit on/off, clearing aborts conversion
// - start bit begins single or free-running
// - first conversion 25 cycles, others 13
// - start reads one while busy; zero ignored
// - auto trigger starts on selected rising edge
// - flag set at every conversion end, even while locked
// - interrupt while flag, enable, global set
// - vector or written one clears flag
// - three-bit prescaler divides system clock
// - right adjust layout of result bytes
// - left adjust layout of result bytes
// - low read locks result until high read
// - differential result shown two's complement
// - left adjust changes presentation immediately
// - free-running select makes no trigger itself
// - source switch to set source triggers
`timescale 1ns/10ps
`default_nettype none
module acr_adc_control (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // cpu interrupt handshake
    input wire logic global_irq_enable,
    input wire logic irq_vector_taken,
    output logic completion_irq,
    // trigger sources 1..7, asynchronous
    input wire logic [6:0] trigger_in,
    // analog core
    output acr_pkg::acr_core_req_s core_req,
    input wire logic [9:0] core_code
);
    import acr_pkg::*;

    acr_state_s state_reg;
    acr_state_s state_next;

    // ************************************************************
    // apb decode
    // ************************************************************
    logic access;
    logic do_write;
    logic do_read;
    logic mapped;
    assign access = psel && penable;
    // effects land only on the edge where pready is seen high
    assign do_write = access && state_reg.apb.pready && pwrite;
    assign do_read = access && state_reg.apb.pready && !pwrite;
    assign mapped = (paddr == OFS_INPUT_GAIN_SELECT) || (paddr == OFS_CONTROL_STATUS)
        || (paddr == OFS_CONTROL_B) || (paddr == OFS_RESULT_LOW) || (paddr == OFS_RESULT_HIGH);

    // ************************************************************
    // result presentation
    // ************************************************************
    logic [7:0] res_low;
    logic [7:0] res_high;
    always_comb begin
        if (state_reg.left_adjust) begin
            res_high = state_reg.result[9:2];
            res_low = {state_reg.result[1:0], 6'h00};
        end else begin
            res_high = {6'h00, state_reg.result[9:8]};
            res_low = state_reg.result[7:0];
        end
    end

    logic [7:0] control_view;
    always_comb begin
        control_view = RST_BYTE;
        control_view[BIT_ENABLE] = state_reg.converter_enable;
        control_view[BIT_START] = (state_reg.fsm == ACR_CONVERT);
        control_view[BIT_AUTO] = state_reg.auto_trigger_enable;
        control_view[BIT_FLAG] = state_reg.completion_flag;
        control_view[BIT_IRQ_EN] = state_reg.completion_irq_enable;
        control_view[2:0] = state_reg.clock_divider_select;
    end

    logic [7:0] read_byte;
    always_comb begin
        case (paddr)
            OFS_INPUT_GAIN_SELECT: read_byte = {state_reg.ref_sel, state_reg.left_adjust,
                state_reg.input_select_field};
            OFS_CONTROL_STATUS: read_byte = control_view;
            OFS_CONTROL_B: read_byte = {5'h00, state_reg.trigger_source_select};
            OFS_RESULT_LOW: read_byte = res_low;
            OFS_RESULT_HIGH: read_byte = res_high;
            default: read_byte = RST_BYTE;
        endcase
    end

    // ************************************************************
    // channel decode
    // ************************************************************
    logic sel_diff;
    acr_gain_e sel_gain;
    always_comb begin
        sel_diff = !((state_reg.input_select_field <= SEL_LAST_SINGLE)
            || (state_reg.input_select_field == SEL_BANDGAP)
            || (state_reg.input_select_field == SEL_GROUND));
        if (!sel_diff || state_reg.input_select_field >= SEL_FIRST_X1) begin
            sel_gain = ACR_GAIN_1X;
        end else if (state_reg.input_select_field[1]) begin
            sel_gain = ACR_GAIN_200X;
        end else begin
            sel_gain = ACR_GAIN_10X;
        end
    end

    // ************************************************************
    // trigger selection
    // ************************************************************
    logic trig_level;
    logic trig_edge;
    always_comb begin
        // free-running source reads as low, so no edge
        if (state_reg.trigger_source_select == TS_FREE_RUN) begin
            trig_level = 1'b0;
        end else begin
            trig_level = state_reg.trig_sync[state_reg.trigger_source_select - 3'h1];
        end
    end
    // edge on selected level, so a source switch counts
    assign trig_edge = trig_level && !state_reg.trig_prev;

    // ************************************************************
    // next state
    // ************************************************************
    logic wr_ctrl;
    logic pre_tick;
    logic conv_end;
    logic start_req;
    logic flag_set;
    logic [4:0] conv_last;
    always_comb begin
        state_next = state_reg;
        wr_ctrl = do_write && (paddr == OFS_CONTROL_STATUS);
        pre_tick = (state_reg.pre_cnt == div_last(state_reg.clock_divider_select));
        conv_last = state_reg.first_pending ? CONV_LAST_FIRST : CONV_LAST_NORMAL;
        conv_end = (state_reg.fsm == ACR_CONVERT) && pre_tick && (state_reg.conv_cnt == conv_last);
        flag_set = 1'b0;
        start_req = 1'b0;

        // pin inputs through two flops
        state_next.trig_meta = trigger_in;
        state_next.trig_sync = state_reg.trig_meta;
        state_next.trig_prev = trig_level;

        // apb handshake: one wait state
        state_next.apb.pready = access && !state_reg.apb.pready;
        state_next.apb.pslverr = access && !state_reg.apb.pready && !mapped;
        state_next.apb.prdata = (access && !state_reg.apb.pready && !pwrite) ? {24'h000000, read_byte}
            : RST_WORD;

        // register writes
        if (do_write && paddr == OFS_INPUT_GAIN_SELECT) begin
            state_next.ref_sel = pwdata[7:6];
            state_next.left_adjust = pwdata[BIT_LEFT_ADJ];
            state_next.input_select_field = pwdata[4:0];
        end
        if (do_write && paddr == OFS_CONTROL_B) begin
            state_next.trigger_source_select = pwdata[2:0];
        end
        if (wr_ctrl) begin
            state_next.converter_enable = pwdata[BIT_ENABLE];
            state_next.auto_trigger_enable = pwdata[BIT_AUTO];
            state_next.completion_irq_enable = pwdata[BIT_IRQ_EN];
            state_next.clock_divider_select = pwdata[2:0];
            // enabling arms the long first conversion
            if (pwdata[BIT_ENABLE] && !state_reg.converter_enable) begin
                state_next.first_pending = 1'b1;
            end
            if (pwdata[BIT_START]) begin
                start_req = 1'b1;
            end
        end

        // auto trigger on selected rising edge
        if (state_reg.auto_trigger_enable && trig_edge) begin
            start_req = 1'b1;
        end

        // low read locks, high read releases
        if (do_read && paddr == OFS_RESULT_LOW) begin
            state_next.read_lock = 1'b1;
        end
        if (do_read && paddr == OFS_RESULT_HIGH) begin
            state_next.read_lock = 1'b0;
        end

        // prescaler runs only while enabled
        if (!state_reg.converter_enable || pre_tick) begin
            state_next.pre_cnt = PRE_ZERO;
        end else begin
            state_next.pre_cnt = state_reg.pre_cnt + 7'h01;
        end

        state_next.core.start = 1'b0;
        case (state_reg.fsm)
            ACR_IDLE: begin
                state_next.core.channel = state_reg.input_select_field;
                state_next.core.gain = sel_gain;
                state_next.core.differential = sel_diff;
                if (start_req && (state_next.converter_enable)) begin
                    state_next.fsm = ACR_CONVERT;
                    state_next.conv_cnt = CONV_ZERO;
                    state_next.pre_cnt = PRE_ZERO;
                    state_next.conv_diff = sel_diff;
                    state_next.core.start = 1'b1;
                end
            end
            ACR_CONVERT: begin
                if (pre_tick) begin
                    state_next.conv_cnt = state_reg.conv_cnt + 5'h01;
                end
                if (conv_end) begin
                    state_next.fsm = ACR_IDLE;
                    state_next.first_pending = 1'b0;
                    state_next.conv_cnt = CONV_ZERO;
                    if (!state_reg.read_lock) begin
                        state_next.result = state_reg.conv_diff ? {~core_code[9], core_code[8:0]}
                            : core_code;
                    end
                    flag_set = 1'b1;
                    if (state_reg.auto_trigger_enable && state_reg.trigger_source_select == TS_FREE_RUN
                        && state_next.converter_enable) begin
                        state_next.fsm = ACR_CONVERT;
                        state_next.pre_cnt = PRE_ZERO;
                        state_next.core.channel = state_reg.input_select_field;
                        state_next.core.gain = sel_gain;
                        state_next.core.differential = sel_diff;
                        state_next.conv_diff = sel_diff;
                        state_next.core.start = 1'b1;
                    end
                end
                if (!state_next.converter_enable) begin
                    state_next.fsm = ACR_IDLE;
                    state_next.conv_cnt = CONV_ZERO;
                    state_next.core.start = 1'b0;
                    flag_set = 1'b0;
                    state_next.result = state_reg.result;
                end
            end
            default: begin
                state_next.fsm = ACR_IDLE;
            end
        endcase

        // vector or written one clears; a new set wins
        if (flag_set) begin
            state_next.completion_flag = 1'b1;
        end else if (irq_vector_taken || (wr_ctrl && pwdata[BIT_FLAG])) begin
            state_next.completion_flag = 1'b0;
        end

        // interrupt request from flag and enables
        state_next.irq = state_next.completion_flag && state_next.completion_irq_enable && global_irq_enable;
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge clock) begin
        if (srst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign prdata = state_reg.apb.prdata;
    assign pready = state_reg.apb.pready;
    assign pslverr = state_reg.apb.pslverr;
    assign completion_irq = state_reg.irq;
    assign core_req = state_reg.core;
endmodule : acr_adc_control
`default_nettype wire

// >>> test/acr_adc_control_asserts.sv
// Purpose: port-level checks of the converter control block
// Assumes: one clock domain, srst synchronous and active high
// Notes: bound to the design from the bench top file
`timescale 1ns/10ps
`default_nettype none
module acr_adc_control_chk (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // interrupt and core
    input wire logic global_irq_enable,
    input wire logic completion_irq,
    input wire acr_pkg::acr_core_req_s core_req
);
    import acr_pkg::*;
    logic [4:0] sel_reg;
    logic [4:0] sel_next;
    logic sel_wr;
    // last completed select write, what the next start must carry
    assign sel_wr = psel && penable && pready && pwrite && paddr == OFS_INPUT_GAIN_SELECT;
    assign sel_next = sel_wr ? pwdata[4:0] : sel_reg;
    always_ff @(posedge clock) begin
        sel_reg <= srst ? 5'h00 : sel_next;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    // ******************************
    // properties
    // ******************************
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    a_apb_wait: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_err_decode: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10}))
        else $error("pslverr does not match address");
    a_rdata_quiet: assert property (prdata[31:8] == 24'h000000 && (pready && !pwrite || prdata == 32'h00000000))
        else $error("prdata driven outside read answer");
    a_reset_quiet: assert property (disable iff (1'b0) srst |=> !pready && !completion_irq && !core_req.start)
        else $error("outputs active after reset");
    a_irq_gate: assert property (!global_irq_enable |=> !completion_irq)
        else $error("interrupt while globally masked");
    a_start_gap: assert property (core_req.start |=> !core_req.start [*3])
        else $error("conversion starts too close");
    a_start_chan: assert property (core_req.start && !$past(sel_wr) |-> core_req.channel == sel_reg)
        else $error("conversion channel not the written select");
    a_diff_mode: assert property (core_req.start |-> core_req.differential == (core_req.channel inside {[5'h08:5'h1D]}))
        else $error("differential flag wrong for select code");
    a_gain_map: assert property (core_req.start && core_req.differential |-> core_req.gain ==
        (core_req.channel >= SEL_FIRST_X1 ? ACR_GAIN_1X : core_req.channel[1] ? ACR_GAIN_200X : ACR_GAIN_10X))
        else $error("gain wrong for select code");
endmodule : acr_adc_control_chk
`default_nettype wire

// >>> test/acr_adc_control_tb_top.sv
// Purpose: self-checking bench for the converter control block
// Assumes: core_code stands in for the analog core
// Notes: expectations come from register layouts and timing rules
`timescale 1ns/10ps
`default_nettype none
module acr_adc_control_tb_top;
    import acr_pkg::*;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic gie = 1'b1;
    logic ivt = 1'b0;
    logic irq;
    logic [6:0] trig = 7'h00;
    acr_core_req_s core_req;
    logic [9:0] core_code = 10'h000;
    int fail_count = 0;
    int comparisons = 0;
    logic [31:0] rd;
    logic er;
    int n;
    int g;
    logic [4:0] sel_tab [8] = '{5'h00, 5'h07, 5'h08, 5'h0B, 5'h10, 5'h1D, 5'h1E, 5'h1F};
    always #2.5 clock = ~clock;
    acr_adc_control dut (.clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .global_irq_enable(gie), .irq_vector_taken(ivt), .completion_irq(irq), .trigger_in(trig),
        .core_req(core_req), .core_code(core_code));
    // ******************************
    // tasks
    // ******************************
    task automatic end_sim;
        $display("mismatches %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 50);
        chk({31'h0, pready}, 32'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // counts edges until a start pulse is seen, lim if none
    task automatic wait_start(input int lim, output int c);
        c = 0;
        do begin
            @(posedge clock);
            c++;
        end while (core_req.start !== 1'b1 && c < lim);
    endtask : wait_start
    task automatic wait_irq;
        int k;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (irq !== 1'b1 && k < 5000);
        chk({31'h0, irq}, 32'h1);
    endtask : wait_irq
    // ******************************
    // tests
    // ******************************
    initial begin
        repeat (60000) @(posedge clock);
        fail_count++;
        $display("[ERR] %0t watchdog expired", $time);
        end_sim;
    end
    initial begin
        repeat (20) @(posedge clock);
        srst <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk(rd, RST_WORD);
        end
        apb(1'b1, OFS_RESULT_LOW, 32'h000000FF);
        apb(1'b0, OFS_RESULT_LOW, 32'h0);
        chk(rd, RST_WORD);
        // low read above locked the result; high read releases it
        apb(1'b0, OFS_RESULT_HIGH, 32'h0);
        chk(rd, RST_WORD);
        apb(1'b0, 8'h14, 32'h0);
        chk({31'h0, er}, 32'h1);
        $display("test registers done");
        for (int c = 0; c < 8; c++) begin
            g = (c < 2) ? 2 : (1 << c);
            apb(1'b1, OFS_CONTROL_STATUS, 32'h00000010);
            apb(1'b1, OFS_INPUT_GAIN_SELECT, {27'h0, sel_tab[c]});
            apb(1'b1, OFS_CONTROL_STATUS, 32'h000000E0 | 32'(c));
            wait_start(20000, n);
            chk({27'h0, core_req.channel}, {27'h0, sel_tab[c]});
            wait_start(20000, n);
            chk(32'(n), 32'(25 * g));
            wait_start(20000, n);
            chk(32'(n), 32'(13 * g));
        end
        $display("test timing done");
        apb(1'b1, OFS_CONTROL_STATUS, 32'h00000010);
        core_code <= 10'h2C5;
        apb(1'b1, OFS_INPUT_GAIN_SELECT, 32'h00000003);
        apb(1'b1, OFS_CONTROL_STATUS, 32'h000000CF);
        apb(1'b1, OFS_CONTROL_STATUS, 32'h0000008F);
        apb(1'b1, OFS_INPUT_GAIN_SELECT, 32'h00000005);
        chk({27'h0, core_req.channel}, 32'h3);
        apb(1'b0, OFS_CONTROL_STATUS, 32'h0);
        chk(rd, 32'h000000CF);
        wait_irq;
        apb(1'b0, OFS_CONTROL_STATUS, 32'h0);
        chk(rd, 32'h0000009F);
        apb(1'b0, OFS_RESULT_LOW, 32'h0);
        chk(rd, 32'h000000C5);
        apb(1'b0, OFS_RESULT_HIGH, 32'h0);
        chk(rd, 32'h00000002);
        apb(1'b1, OFS_INPUT_GAIN_SELECT, 32'h00000025);
        apb(1'b0, OFS_RESULT_HIGH, 32'h0);
        chk(rd, 32'h000000B1);
        apb(1'b0, OFS_RESULT_LOW, 32'h0);
        chk(rd, 32'h00000040);
        apb(1'b0, OFS_RESULT_HIGH, 32'h0);
        chk(rd, 32'h000000B1);
        gie <= 1'b0;
        repeat (3) @(posedge clock);
        chk({31'h0, irq}, 32'h0);
        gie <= 1'b1;
        apb(1'b1, OFS_CONTROL_STATUS, 32'h0000008F);
        chk({31'h0, irq}, 32'h1);
        ivt <= 1'b1;
        @(posedge clock);
        ivt <= 1'b0;
        repeat (3) @(posedge clock);
        chk({31'h0, irq}, 32'h0);
        $display("test single done");
        core_code <= 10'h070;
        apb(1'b1, OFS_INPUT_GAIN_SELECT, 32'h00000009);
        apb(1'b1, OFS_CONTROL_STATUS, 32'h000000DF);
        wait_irq;
        // sign bit lands in the high byte, so look there too
        apb(1'b0, OFS_RESULT_HIGH, 32'h0);
        chk(rd, 32'h00000002);
        apb(1'b0, OFS_RESULT_LOW, 32'h0);
        chk(rd, 32'h00000070);
        core_code <= 10'h155;
        apb(1'b1, OFS_CONTROL_STATUS, 32'h000000DF);
        wait_irq;
        apb(1'b0, OFS_RESULT_HIGH, 32'h0);
        chk(rd, 32'h00000002);
        apb(1'b0, OFS_RESULT_LOW, 32'h0);
        chk(rd, 32'h00000070);
        apb(1'b1, OFS_CONTROL_STATUS, 32'h000000DF);
        apb(1'b1, OFS_CONTROL_STATUS, 32'h00000008);
        repeat (3300) @(posedge clock);
        chk({31'h0, irq}, 32'h0);
        $display("test lock and abort done");
        apb(1'b1, OFS_CONTROL_B, 32'h00000002);
        apb(1'b1, OFS_CONTROL_STATUS, 32'h000000B8);
        trig <= 7'h02;
        wait_start(20, n);
        chk({31'h0, core_req.start}, 32'h1);
        repeat (60) @(posedge clock);
        trig <= 7'h08;
        apb(1'b1, OFS_CONTROL_B, 32'h00000004);
        wait_start(20, n);
        chk({31'h0, core_req.start}, 32'h1);
        repeat (60) @(posedge clock);
        apb(1'b1, OFS_CONTROL_B, 32'h00000000);
        wait_start(100, n);
        chk(32'(n), 32'd100);
        $display("test trigger done");
        end_sim;
    end
endmodule : acr_adc_control_tb_top
bind acr_adc_control acr_adc_control_chk u_chk (.clock(clock), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .global_irq_enable(global_irq_enable), .completion_irq(completion_irq), .core_req(core_req));
`default_nettype wire
